/* File: ofc_amp_model.sv */
// Amplifier and comparator model at the far side of the sequencer
`timescale 1ns/1ps
module ofc_amp_model import ofc_pkg::*; #(
	parameter int NCH = NCH_DEF
) (
	// Amplifier input offset and the correction applied to it
	input  wire logic [NCH-1:0][7:0]       offs,      // Input offset, two's complement
	input  wire logic [NCH-1:0][RES_W-1:0] offs_code, // Correction from the sequencer
	// Comparator levels toward the sequencer
	output logic      [NCH-1:0]            comp_in    // High when output above threshold
);
	// Sense current held at zero: only offset plus correction remain
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			comp_in[i] = $signed(offs[i]) + $signed(offs_code[i]) > 0;
		end
	end
endmodule

/* File: ofc_chan.sv */
// One channel of the offset compensation stepping engine
`timescale 1ns/1ps
module ofc_chan import ofc_pkg::*; #(
	parameter int STEP_C = STEP_CYC,
	parameter int RUN_C  = RUN_CYC
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Microcore command and synchronised comparator
	input  wire ofc_cmd_t cmd,
	input  wire logic     comp,
	// Channel state
	output ofc_stat_t     stat
);
	localparam int SW = $clog2(STEP_C + 1);
	localparam int RW = $clog2(RUN_C + 1);

	typedef enum logic [0:0] {OFC_IDLE = 1'h0, OFC_RUN = 1'h1} ofc_state_t;

	// One code step; kept positive so sign extension cannot turn it into -1
	localparam logic signed [RES_W-1:0] CODE_STEP = RES_W'(1);

	ofc_state_t              state_reg;    // Engine state
	logic [SW-1:0]           step_reg;     // Cycles within current step
	logic [RW-1:0]           run_reg;      // Cycles since run start
	logic                    first_reg;    // No step decided yet
	logic                    dir_reg;      // Last direction, 1 is down
	logic                    done_reg;     // Run completed normally
	logic signed [RES_W-1:0] code_reg;     // Retained result

	// Decisions of the current cycle
	wire step_end = (step_reg == SW'(STEP_C - 1));
	wire run_end  = (run_reg == RW'(RUN_C - 1));
	wire dir_dn   = comp;
	wire reversed = !first_reg && (dir_dn != dir_reg);
	wire at_limit = dir_dn ? (code_reg == RES_MIN) : (code_reg == RES_MAX);
	wire settle   = step_end && (reversed || at_limit);
	wire finish   = run_end || settle;

	// Run sequencing; the start command begins a run, a stop or the run's own completion ends it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= OFC_IDLE;
			step_reg  <= '0;
			run_reg   <= '0;
			first_reg <= 1'h1;
			dir_reg   <= 1'h0;
			done_reg  <= 1'h0;
			code_reg  <= '0;
		end else begin
			unique case (state_reg)
				OFC_IDLE: begin
					if (cmd.start) begin
						// Result is kept, stepping resumes from it
						state_reg <= OFC_RUN;
						step_reg  <= '0;
						run_reg   <= '0;
						first_reg <= 1'h1;
						done_reg  <= 1'h0;
					end else if (cmd.stop) begin
						done_reg  <= 1'h0;
					end
				end
				OFC_RUN: begin
					if (cmd.stop) begin
						// Abort keeps the code reached so far
						state_reg <= OFC_IDLE;
					end else if (finish) begin
						state_reg <= OFC_IDLE;
						done_reg  <= 1'h1;
					end else begin
						run_reg  <= run_reg + 1'h1;
						step_reg <= step_end ? '0 : step_reg + 1'h1;
						if (step_end) begin
							// One code step toward the comparator's side
							code_reg  <= dir_dn ? code_reg - CODE_STEP :
							             code_reg + CODE_STEP;
							dir_reg   <= dir_dn;
							first_reg <= 1'h0;
						end
					end
				end
			endcase
		end
	end

	assign stat.busy = (state_reg == OFC_RUN);
	assign stat.done = done_reg;
	assign stat.code = code_reg;
endmodule

/* File: ofc_pkg.sv */
// Package with constants and carrier types of the offset compensation sequencer
package ofc_pkg;
	// Channels 1, 2, 3, 4L, 4H
	localparam int NCH_DEF = 5;
	localparam int DAC_W   = 8;
	localparam int RES_W   = 6;
	localparam int GAIN_W  = 2;

	// Bias code of the threshold DAC during a run
	localparam logic [DAC_W-1:0] DAC_BIAS_CODE = 8'h1A;

	// Signed result limits
	localparam logic signed [RES_W-1:0] RES_MAX = 6'sh1F;
	localparam logic signed [RES_W-1:0] RES_MIN = -6'sh1F;

	// Gain codes
	localparam logic [GAIN_W-1:0] GAIN_MAX  = 2'h3;
	localparam logic [GAIN_W-1:0] GAIN_RST  = 2'h3;

	// Timing, in ns, and derived cycle counts at 125 MHz
	localparam int CLK_NS      = 8;
	localparam int T_STEP_NS   = 2000;
	localparam int T_RUN_NS    = 62000;
	localparam int RUN_STEPS   = 63;
	// Longest step that still lets a full sweep fit in the run time
	localparam int STEP_NS     = (T_RUN_NS / RUN_STEPS < T_STEP_NS) ?
		T_RUN_NS / RUN_STEPS : T_STEP_NS;
	localparam int STEP_CYC    = STEP_NS / CLK_NS;
	localparam int RUN_CYC     = T_RUN_NS / CLK_NS;

	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RES0   = 8'h08;

	// Status word field positions
	localparam int ST_BUSY_LSB = 0;
	localparam int ST_DONE_LSB = 8;

	// Microcore command pair per channel
	typedef struct packed {
		logic start;
		logic stop;
	} ofc_cmd_t;

	// Per-channel state seen by the top
	typedef struct packed {
		logic                    busy;
		logic                    done;
		logic signed [RES_W-1:0] code;
	} ofc_stat_t;
endpackage

/* File: ofc_seq.sv */
// Offset compensation sequencer top with APB register slave
`timescale 1ns/1ps
module ofc_seq import ofc_pkg::*; #(
	parameter int NCH    = NCH_DEF,
	parameter int STEP_C = STEP_CYC,
	parameter int RUN_C  = RUN_CYC
) (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Microcore start and stop pulses, one per instruction, and the level threshold request
	input  wire logic [NCH-1:0]                oc_start,
	input  wire logic [NCH-1:0]                oc_stop,
	input  wire logic [NCH-1:0][DAC_W-1:0]     thr_dac_req,
	// Analog comparator outputs, asynchronous
	input  wire logic [NCH-1:0]                comp_in,
	// Analog and microcore facing outputs
	output logic      [NCH-1:0][DAC_W-1:0]     thr_dac,
	output logic      [NCH-1:0][RES_W-1:0]     offs_code,
	output logic      [NCH-1:0]                fbk_out,
	output logic      [GAIN_W-1:0]             amp_gain_select
);
	// Parameters the logic cannot serve are refused
	if (NCH < 1 || NCH > 8 || STEP_C < 1 || RUN_C < STEP_C) begin : g_chk
		$error("ofc_seq: bad NCH, STEP_C or RUN_C");
	end

	logic [NCH-1:0] comp_s1_reg;     // Synchroniser first stage
	logic [NCH-1:0] comp_s2_reg;     // Synchroniser second stage
	ofc_stat_t      stat [NCH];      // Channel states
	logic [GAIN_W-1:0] gain_reg;     // Amplifier gain code

	// Two-stage synchroniser on comparator pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_s1_reg <= '0;
			comp_s2_reg <= '0;
		end else begin
			comp_s1_reg <= comp_in;
			comp_s2_reg <= comp_s1_reg;
		end
	end

	// Per-channel engines and their pin drivers
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		ofc_cmd_t cmd;
		assign cmd.start = oc_start[c];
		assign cmd.stop  = oc_stop[c];

		ofc_chan #(.STEP_C(STEP_C), .RUN_C(RUN_C)) u_chan (
			.pclk    (pclk),
			.presetn (presetn),
			.cmd     (cmd),
			.comp    (comp_s2_reg[c]),
			.stat    (stat[c])
		);

		// Bias code while running, microcore threshold otherwise
		wire [DAC_W-1:0] dac_next = stat[c].busy ? DAC_BIAS_CODE : thr_dac_req[c];
		// Feedback held low during and after a completed run
		wire fbk_next = comp_s2_reg[c] & ~stat[c].busy & ~stat[c].done;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				thr_dac[c]   <= '0;
				fbk_out[c]   <= 1'h0;
				offs_code[c] <= '0;
			end else begin
				thr_dac[c]   <= dac_next;
				fbk_out[c]   <= fbk_next;
				offs_code[c] <= stat[c].code;
			end
		end
	end

	// Collected status bits
	logic [NCH-1:0] busy_v;
	logic [NCH-1:0] done_v;
	for (genvar c = 0; c < NCH; c++) begin : g_st
		assign busy_v[c] = stat[c].busy;
		assign done_v[c] = stat[c].done;
	end

	// APB decode
	wire        setup    = psel & ~penable;
	wire        wr_acc   = psel & penable & pwrite;
	wire        hit_ctrl = (paddr == OFS_CTRL);
	wire        hit_stat = (paddr == OFS_STATUS);
	wire [7:0]  res_off  = paddr - OFS_RES0;
	wire [5:0]  res_idx  = res_off[7:2];
	wire        hit_res  = (paddr >= OFS_RES0) && (res_off[1:0] == 2'h0) &&
	                       (res_idx < 6'(NCH));
	wire        mapped   = hit_ctrl | hit_stat | hit_res;
	wire [2:0]  res_sel  = res_idx[2:0];
	wire [RES_W-1:0] res_word = stat[res_sel].code;
	wire [31:0] st_word  = (32'(busy_v) << ST_BUSY_LSB) | (32'(done_v) << ST_DONE_LSB);
	wire [31:0] rd_mux   = hit_ctrl ? 32'(gain_reg) :
	                       hit_stat ? st_word :
	                       hit_res  ? 32'(res_word) : 32'h0000_0000;

	// No wait state: answer prepared in setup, given in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'h0;
			pslverr <= 1'h0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Gain register, written at the completing access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_reg <= GAIN_RST;
		end else if (wr_acc && pready && hit_ctrl) begin
			gain_reg <= pwdata[GAIN_W-1:0];
		end
	end

	assign amp_gain_select = gain_reg;
endmodule

/* File: ofc_seq_sva.sv */
// Port checker of the offset compensation sequencer, channel 0; code range on all channels
`timescale 1ns/1ps
module ofc_seq_sva import ofc_pkg::*; #(
	parameter int NCH    = NCH_DEF,
	parameter int STEP_C = STEP_CYC,
	parameter int RUN_C  = RUN_CYC
) (
	// Clock and reset
	input wire logic                      pclk,
	input wire logic                      presetn,
	// APB request and error
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic                      pslverr,
	input wire logic [7:0]                paddr,
	// Microcore commands and feedback
	input wire logic [NCH-1:0]            oc_start,
	input wire logic [NCH-1:0]            oc_stop,
	input wire logic [NCH-1:0]            fbk_out,
	// Analog side outputs
	input wire logic [NCH-1:0][DAC_W-1:0] thr_dac,
	input wire logic [NCH-1:0][RES_W-1:0] offs_code,
	input wire logic [GAIN_W-1:0]         amp_gain_select
);
	int run_cnt;   // Cycles with the bias code applied
	int stall_cnt; // Run cycles without a code change
	wire bias = thr_dac[0] == DAC_BIAS_CODE;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Count run length and gaps between steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cnt   <= 0;
			stall_cnt <= 0;
		end else begin
			run_cnt   <= bias ? run_cnt + 1 : 0;
			stall_cnt <= (bias && offs_code[0] == $past(offs_code[0])) ? stall_cnt + 1 : 0;
		end
	end
	a_bias_load: assert property (oc_start[0] && !oc_stop[0] |-> ##2 bias)
		else $error("bias code not loaded");
	a_fbk_quiet: assert property (bias [*2] |-> !fbk_out[0])
		else $error("feedback not low in run");
	// Channels showing -32, the code a missed saturation wraps to either way
	logic [NCH-1:0] wrap_v;
	for (genvar i = 0; i < NCH; i++) begin : g_wrap
		assign wrap_v[i] = (offs_code[i] == 6'h20);
	end
	a_code_range: assert property (wrap_v == '0)
		else $error("code out of range");
	a_single_step: assert property (!$stable(offs_code[0]) |->
		6'(offs_code[0] - $past(offs_code[0])) inside {6'h01, 6'h3F})
		else $error("code moved more than one step");
	a_idle_hold: assert property (!bias [*4] |-> $stable(offs_code[0]))
		else $error("code moved while idle");
	a_run_bound: assert property (run_cnt <= RUN_C + 2)
		else $error("run too long");
	a_step_time: assert property (stall_cnt <= STEP_C + 3)
		else $error("step too slow");
	a_gain_write: assert property (!$stable(amp_gain_select) |->
		$past(psel && penable && pwrite && paddr == OFS_CTRL))
		else $error("gain changed without write");
	c_run: cover property (bias [*3]);
	c_settle: cover property (offs_code[0] == 6'h3E);
	c_err: cover property (pslverr);
endmodule

bind ofc_seq ofc_seq_sva #(.NCH(NCH), .STEP_C(STEP_C), .RUN_C(RUN_C)) u_sva (.pclk, .presetn,
	.psel, .penable, .pwrite, .pslverr, .paddr, .oc_start, .oc_stop, .fbk_out, .thr_dac,
	.offs_code, .amp_gain_select);

/* File: offset_comp_sequencer_bench.sv */
// Self-checking bench of the offset compensation sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module offset_comp_sequencer_bench;
	import ofc_pkg::*;
	localparam int NCH = 5;
	localparam int STP = 6;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, rd, prdata;
	logic [NCH-1:0] oc_start = '0, oc_stop = '0, comp_in, fbk_out;
	logic [NCH-1:0][DAC_W-1:0] thr_dac_req = {NCH{8'h55}}, thr_dac;
	logic [NCH-1:0][RES_W-1:0] offs_code;
	logic [NCH-1:0][7:0] offs = '0;
	logic [GAIN_W-1:0] amp_gain_select;
	int miscompares = 0, checks = 0, cyc = 0;
	ofc_seq #(.NCH(NCH), .STEP_C(STP), .RUN_C(300)) u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oc_start, .oc_stop,
		.thr_dac_req, .comp_in, .thr_dac, .offs_code, .fbk_out, .amp_gain_select);
	ofc_amp_model #(.NCH(NCH)) u_amp (.offs, .offs_code, .comp_in);
	initial forever #4 pclk = ~pclk;
	// Cut a hang short
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test;
		end
	end
	task stop_test;
		if (miscompares == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One APB transfer, held until pready, then one idle edge before the next
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata; err = pslverr; psel <= 1'h0; penable <= 1'h0;
		@(posedge pclk);
	endtask
	task pulse(input int ch, input logic stp);
		if (stp) oc_stop[ch] <= 1'h1;
		else oc_start[ch] <= 1'h1;
		@(posedge pclk);
		oc_stop <= '0; oc_start <= '0;
	endtask
	task wait_done(input int ch);
		do apb(1'h0, OFS_STATUS, 32'h0); while (rd[ST_DONE_LSB+ch] !== 1'h1);
	endtask
	task t_regs;
		apb(1'h0, OFS_CTRL, 32'h0); `CHK(rd, 32'h3)
		`CHK(err, 1'h0)
		apb(1'h1, OFS_CTRL, 32'h1); @(posedge pclk); `CHK(amp_gain_select, 2'h1)
		apb(1'h0, 8'h40, 32'h0); `CHK(err, 1'h1)
		`CHK(rd, 32'h0000_0000)
		apb(1'h1, OFS_CTRL, 32'h3); // Highest gain before runs
	endtask
	task t_run;
		offs[0] <= 8'h05; pulse(0, 1'h0); repeat (2) @(posedge pclk);
		`CHK(thr_dac[0], DAC_BIAS_CODE)
		wait_done(0); `CHK(offs_code[0], 6'h3B)
		`CHK(fbk_out[0], 1'h0)
		offs[0] <= 8'h03; pulse(0, 1'h0); // Rerun after drift
		repeat (STP + 4) @(posedge pclk); `CHK(offs_code[0], 6'h3C)
		wait_done(0); apb(1'h0, OFS_RES0, 32'h0); `CHK(rd, 32'h3E)
		// Comparator is high at this settled code, yet feedback stays low
		`CHK(fbk_out[0], 1'h0)
		// A stop while idle clears done and hands the comparator back
		pulse(0, 1'h1);
		repeat (2) @(posedge pclk);
		`CHK(fbk_out[0], 1'h1)
	endtask
	task t_abort;
		offs[1] <= 8'hD8; pulse(1, 1'h0); repeat (21) @(posedge pclk); pulse(1, 1'h1);
		repeat (20) @(posedge pclk); `CHK(offs_code[1], 6'h03)
		`CHK(thr_dac[1], 8'h55)
		// Abort leaves neither busy nor done standing on any channel
		apb(1'h0, OFS_STATUS, 32'h0);
		`CHK(rd, 32'h0000_0000)
		pulse(1, 1'h0); wait_done(1); `CHK(offs_code[1], RES_MAX)
	endtask
	task t_limit;
		// Sweep channel 2 down to the low limit
		offs[2] <= 8'h28;
		pulse(2, 1'h0);
		wait_done(2);
		`CHK(offs_code[2], RES_MIN)
		// Sweep back up; the run time ends it after 49 steps, at +18
		offs[2] <= 8'hD8;
		pulse(2, 1'h0);
		apb(1'h0, OFS_STATUS, 32'h0);
		`CHK(rd, 32'h0000_0204)
		wait_done(2);
		`CHK(offs_code[2], 6'h12)
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_regs;
		t_run;
		t_abort;
		t_limit;
		stop_test;
	end
endmodule
